// [hdl/cve_defs.svh]
// constants for the channel value evaluator
`ifndef CVE_DEFS_SVH
`define CVE_DEFS_SVH
`define CVE_LEN_EXT      5'd20
`define CVE_LEN_STD      5'd10
`define CVE_CH_SEMI      8'h3b
`define CVE_CH_SLASH     8'h2f
`define CVE_CH_BAR       8'h7c
`define CVE_CH_HASH      8'h23
`define CVE_CH_STAR      8'h2a
`define CVE_CH_J         8'h4a
`define CVE_CH_T         8'h54
`define CVE_CH_P         8'h50
`define CVE_CH_N         8'h4e
`define CVE_CH_MARK      8'h7e
`define CVE_CH_BLANK     8'h20
`define CVE_SMOOTH_MAX   7'h63
`define CVE_HYST_MAX     7'h63
`define CVE_HYST_RST     7'h0a
`define CVE_LOCK_NONE    3'h0
`define CVE_LOCK_RANGE   3'h1
`define CVE_LOCK_UNITS   3'h3
`define CVE_LOCK_CORR    3'h4
`define CVE_LOCK_SCALE   3'h5
`define CVE_LOCK_ANALOG  3'h6
`define CVE_LOCK_LIMIT   3'h7
`define CVE_ALARM_VAL    16'h03e8
`define CVE_LIM_MAX_RST  16'h7fff
`define CVE_LIM_MIN_RST  16'h8000
`define CVE_TC_SCALE     16'h000a
`endif

// [hdl/cve_pkg.sv]
// types for the channel value evaluator
package cve_pkg;
  typedef enum logic [2:0] {FN_MEAS, FN_DIFF, FN_MAX, FN_MIN, FN_AVG, FN_ALARM} cve_out_fn_t;
  typedef enum logic [1:0] {AVG_NONE, AVG_CONTINUOUS_SCAN_AVERAGE, AVG_PER_CYCLE_AVERAGE} cve_avg_mode_t;
  typedef enum logic [1:0] {ACT_ALARM_ONLY, ACT_START, ACT_STOP} cve_action_t;
  typedef enum logic [3:0] {
    PRM_RANGE, PRM_ELEM, PRM_OUT_FN, PRM_UNITS, PRM_CORR, PRM_SCALE, PRM_ANALOG,
    PRM_LIM_MAX, PRM_LIM_MIN, PRM_AVG_MODE, PRM_SMOOTH, PRM_ACT_MAX, PRM_ACT_MIN
  } cve_param_t;
  typedef struct packed {
    logic signed [15:0] val;
    logic               over;
    logic               under;
    logic               brk;
    logic               manual;
  } cve_sample_t;
  typedef struct packed {
    cve_param_t  cls;
    logic [15:0] data;
    logic        confirm;
  } cve_param_wr_t;
  typedef struct packed {
    logic [19:0][7:0]   desig;
    logic [6:0]         smooth_cnt;
    logic [98:0][15:0]  hist;
    logic signed [22:0] sum;
    logic [6:0]         fill;
    logic [6:0]         idx;
    logic signed [15:0] last;
    logic               have_last;
    logic signed [15:0] max;
    logic signed [15:0] min;
    logic [31:0]        max_ts;
    logic [31:0]        min_ts;
    logic               mx_ok;
    logic               mn_ok;
    logic signed [31:0] acc;
    logic [15:0]        avg_n;
    logic signed [15:0] avg_val;
    logic signed [15:0] lim_max;
    logic signed [15:0] lim_min;
    logic [6:0]         hyst;
    cve_out_fn_t        out_fn;
    cve_avg_mode_t      avg_mode;
    cve_action_t        act_max;
    cve_action_t        act_min;
    logic               al_max;
    logic               al_min;
    logic               al_brk;
    logic               run_q;
    logic signed [15:0] out_val;
    logic               out_vld;
    logic [15:0]        tc;
    logic               start_p;
    logic               stop_p;
    logic               wr_done;
    logic               wr_refused;
    logic               confirm_req;
    logic               desig_rej;
  } cve_state_t;
endpackage

// [hdl/cve_evaluator.sv]
// channel value evaluator: designation, smoothing, max/min, averaging, output, locking, limits
// Contract
// - designation up to 20 chars extended, else 10; reject ; / | anywhere, # except in the first position
// - #J uses connector cold junction for thermocouple; *J marks external cj reference
// - *T marks temperature reference, *P marks pressure reference for following channels
// - #N asks conversion of flow results to standard conditions
// - marker appended at end when linearization active; user cannot overwrite it
// - sliding average over programmable count 0 to 99
// - smoothed value feeds max/min, averaging and limit checks
// - time constant equals count over conversion rate, legacy channels count plus one
// - max and min tracked continuously with their timestamps
// - max/min cleared singly or all together; current value reloads at once
// - option clears max, min, average whenever measuring starts
// - three averaging modes: none, continuous start to stop, per cycle
// - per-cycle mode also clears max/min each cycle
// - average and its count available; average clearable alone or with max/min
// - output function selects measured, difference, max, min, average or alarm value
// - locking cumulative by level 0 to 7 over parameter groups
// - write refused when protecting level at or below locking level
// - locked write allowed after explicit confirmation
// - limit, range excess or sensor break raises alarm, indicator and beeper
// - max overshoot and min undershoot indicated and relayed separately
// - alarm holds until value back inside limit by hysteresis
// - global hysteresis 0 to 99 digits, reset 10
// - limit violation may start or stop measuring
`timescale 1ns/1ps
`include "cve_defs.svh"
module cve_evaluator
  import cve_pkg::*;
(
  // clock and reset
  input  wire logic               core_clk,
  input  wire logic               sys_rst,
  // samples
  input  wire logic               smp_valid,
  input  wire cve_sample_t        smp,
  input  wire logic signed [15:0] ch0_val,
  input  wire logic [31:0]        now_ts,
  // channel and run context
  input  wire logic               meas_running,
  input  wire logic               cycle_start,
  input  wire logic               auto_clr_start,
  input  wire logic               is_thermo,
  input  wire logic               is_extended,
  input  wire logic               is_legacy,
  input  wire logic               lin_active,
  input  wire logic [7:0]         conv_rate_hz,
  // clearing
  input  wire logic               clr_max,
  input  wire logic               clr_min,
  input  wire logic               clr_all,
  input  wire logic               clr_avg,
  // designation
  input  wire logic               desig_we,
  input  wire logic [4:0]         desig_idx,
  input  wire logic [7:0]         desig_chr,
  output logic                    desig_rej,
  output logic [19:0][7:0]        desig_out,
  output logic                    cj_ext_ref,
  output logic                    cj_internal,
  output logic                    temp_ref,
  output logic                    press_ref,
  output logic                    std_cond,
  // parameters
  input  wire logic               param_we,
  input  wire cve_param_wr_t      param_wr,
  input  wire logic [2:0]         lock_level,
  input  wire logic               hyst_we,
  input  wire logic [6:0]         hyst_val,
  output logic                    param_done,
  output logic                    param_refused,
  output logic                    confirm_req,
  // results
  output logic signed [15:0]      smooth_val,
  output logic signed [15:0]      max_val,
  output logic [31:0]             max_ts,
  output logic signed [15:0]      min_val,
  output logic [31:0]             min_ts,
  output logic signed [15:0]      avg_val,
  output logic [15:0]             avg_n,
  output logic signed [15:0]      out_val,
  output logic                    out_vld,
  output logic [15:0]             tc_tenths,
  // alarms and actions
  output logic                    alarm_max,
  output logic                    alarm_min,
  output logic                    alarm_brk,
  output logic                    alarm_led,
  output logic                    beeper,
  output logic                    relay_max,
  output logic                    relay_min,
  output logic                    start_req,
  output logic                    stop_req
);
  cve_state_t s_ff;
  cve_state_t nxt_s;

  // protecting level of each parameter group
  function automatic logic [2:0] prot_lvl(input cve_param_t c);
    unique case (c)
      PRM_RANGE, PRM_ELEM, PRM_OUT_FN: prot_lvl = `CVE_LOCK_RANGE;
      PRM_UNITS:                       prot_lvl = `CVE_LOCK_UNITS;
      PRM_CORR:                        prot_lvl = `CVE_LOCK_CORR;
      PRM_SCALE:                       prot_lvl = `CVE_LOCK_SCALE;
      PRM_ANALOG:                      prot_lvl = `CVE_LOCK_ANALOG;
      PRM_LIM_MAX, PRM_LIM_MIN:        prot_lvl = `CVE_LOCK_LIMIT;
      default:                         prot_lvl = `CVE_LOCK_NONE;
    endcase
  endfunction

  logic [4:0]         len;
  logic               chr_bad;
  logic               locked;
  logic               sm_on;
  logic               full;
  logic signed [15:0] old_v;
  logic signed [22:0] sum_n;
  logic [6:0]         fill_n;
  logic signed [22:0] div_s;
  logic signed [15:0] cur;
  logic signed [15:0] cur_now;
  logic               have_now;
  logic               start_rise;
  logic               cyc_clr;
  logic               clr_mx;
  logic               clr_mn;
  logic               clr_av;
  logic               take;
  logic signed [31:0] avg_q;
  logic signed [16:0] rel_max;
  logic signed [16:0] rel_min;
  logic [15:0]        tc_num;

  // designation length and character screening
  assign len     = is_extended ? `CVE_LEN_EXT : `CVE_LEN_STD;
  assign chr_bad = desig_chr == `CVE_CH_SEMI || desig_chr == `CVE_CH_SLASH || desig_chr == `CVE_CH_BAR
                || (desig_chr == `CVE_CH_HASH && desig_idx != 5'h00)
                || desig_idx >= len
                || (lin_active && desig_idx == len - 5'h01);
  assign locked  = prot_lvl(param_wr.cls) != `CVE_LOCK_NONE
                && prot_lvl(param_wr.cls) <= lock_level;

  // sliding window: oldest entry leaves once the window is full
  assign sm_on  = s_ff.smooth_cnt > 7'h01;
  assign full   = s_ff.fill == s_ff.smooth_cnt;
  assign old_v  = full ? $signed(s_ff.hist[s_ff.idx]) : 16'sh0000;
  assign sum_n  = s_ff.sum + 23'(smp.val) - 23'(old_v);
  assign fill_n = full ? s_ff.fill : s_ff.fill + 7'h01;
  assign div_s  = sum_n / $signed({1'b0, fill_n});
  assign cur    = sm_on ? div_s[15:0] : smp.val;
  assign cur_now  = smp_valid ? cur : s_ff.last;
  assign have_now = smp_valid | s_ff.have_last;

  // clear sources
  assign start_rise = meas_running & ~s_ff.run_q;
  assign cyc_clr    = s_ff.avg_mode == AVG_PER_CYCLE_AVERAGE && cycle_start;
  assign clr_mx     = clr_all | clr_max | (auto_clr_start & start_rise) | cyc_clr;
  assign clr_mn     = clr_all | clr_min | (auto_clr_start & start_rise) | cyc_clr;
  assign clr_av     = clr_all | clr_avg | (auto_clr_start & start_rise) | cyc_clr;
  assign take       = smp_valid
                   && ((s_ff.avg_mode == AVG_CONTINUOUS_SCAN_AVERAGE && (meas_running | smp.manual))
                   ||  s_ff.avg_mode == AVG_PER_CYCLE_AVERAGE);
  assign avg_q      = s_ff.acc / $signed({1'b0, s_ff.avg_n});

  // hysteresis release points in digits, one bit wider to avoid wrap
  assign rel_max = 17'(s_ff.lim_max) - $signed({10'h000, s_ff.hyst});
  assign rel_min = 17'(s_ff.lim_min) + $signed({10'h000, s_ff.hyst});
  assign tc_num  = ({9'h000, s_ff.smooth_cnt} + {15'h0000, is_legacy}) * `CVE_TC_SCALE;

  // next state
  always_comb begin
    nxt_s = s_ff;
    nxt_s.start_p     = 1'b0;
    nxt_s.stop_p      = 1'b0;
    nxt_s.wr_done     = 1'b0;
    nxt_s.wr_refused  = 1'b0;
    nxt_s.confirm_req = 1'b0;
    nxt_s.desig_rej   = 1'b0;
    nxt_s.out_vld     = smp_valid;
    nxt_s.run_q       = meas_running;
    nxt_s.tc          = (conv_rate_hz == 8'h00) ? 16'h0000 : tc_num / {8'h00, conv_rate_hz};
    nxt_s.avg_val     = (s_ff.avg_n == 16'h0000) ? 16'sh0000 : avg_q[15:0];
    // designation characters
    if (desig_we) begin
      if (chr_bad) begin
        nxt_s.desig_rej = 1'b1;
      end else begin
        nxt_s.desig[desig_idx] = desig_chr;
      end
    end
    // smoothing window update
    if (smp_valid && sm_on) begin
      nxt_s.hist[s_ff.idx] = smp.val;
      nxt_s.sum  = sum_n;
      nxt_s.fill = fill_n;
      nxt_s.idx  = (s_ff.idx == s_ff.smooth_cnt - 7'h01) ? 7'h00 : s_ff.idx + 7'h01;
    end
    if (smp_valid) begin
      nxt_s.last      = cur;
      nxt_s.have_last = 1'b1;
    end
    // maximum tracking, a clear reloads from the current value
    if (clr_mx) begin
      nxt_s.max    = cur_now;
      nxt_s.max_ts = now_ts;
      nxt_s.mx_ok  = have_now;
    end else if (smp_valid && (!s_ff.mx_ok || cur > s_ff.max)) begin
      nxt_s.max    = cur;
      nxt_s.max_ts = now_ts;
      nxt_s.mx_ok  = 1'b1;
    end
    // minimum tracking
    if (clr_mn) begin
      nxt_s.min    = cur_now;
      nxt_s.min_ts = now_ts;
      nxt_s.mn_ok  = have_now;
    end else if (smp_valid && (!s_ff.mn_ok || cur < s_ff.min)) begin
      nxt_s.min    = cur;
      nxt_s.min_ts = now_ts;
      nxt_s.mn_ok  = 1'b1;
    end
    // averaging accumulator, the count saturates rather than wraps
    if (clr_av) begin
      nxt_s.acc   = take ? 32'(cur) : 32'sh00000000;
      nxt_s.avg_n = take ? 16'h0001 : 16'h0000;
    end else if (take && s_ff.avg_n != 16'hffff) begin
      nxt_s.acc   = s_ff.acc + 32'(cur);
      nxt_s.avg_n = s_ff.avg_n + 16'h0001;
    end
    // limit alarms with hysteresis on release
    if (smp_valid) begin
      nxt_s.al_max = smp.over | (cur > s_ff.lim_max)
                   | (s_ff.al_max & ~(17'(cur) <= rel_max));
      nxt_s.al_min = smp.under | (cur < s_ff.lim_min)
                   | (s_ff.al_min & ~(17'(cur) >= rel_min));
      nxt_s.al_brk = smp.brk;
    end
    // run control on a new violation
    if (nxt_s.al_max && !s_ff.al_max) begin
      nxt_s.start_p = s_ff.act_max == ACT_START;
      nxt_s.stop_p  = s_ff.act_max == ACT_STOP;
    end
    if (nxt_s.al_min && !s_ff.al_min) begin
      nxt_s.start_p = nxt_s.start_p | (s_ff.act_min == ACT_START);
      nxt_s.stop_p  = nxt_s.stop_p | (s_ff.act_min == ACT_STOP);
    end
    // output function: the chosen value is registered into out_val on each sample
    if (smp_valid) begin
      unique case (s_ff.out_fn)
        FN_MEAS:  nxt_s.out_val = cur;
        FN_DIFF:  nxt_s.out_val = cur - ch0_val;
        FN_MAX:   nxt_s.out_val = nxt_s.max;
        FN_MIN:   nxt_s.out_val = nxt_s.min;
        FN_AVG:   nxt_s.out_val = s_ff.avg_val;
        FN_ALARM: nxt_s.out_val = (nxt_s.al_max | nxt_s.al_min) ? `CVE_ALARM_VAL : 16'sh0000;
        default:  nxt_s.out_val = cur;
      endcase
    end
    // parameter writes behind the lock
    if (param_we) begin
      if (locked && !param_wr.confirm) begin
        nxt_s.wr_refused  = 1'b1;
        nxt_s.confirm_req = 1'b1;
      end else begin
        nxt_s.wr_done = 1'b1;
        unique case (param_wr.cls)
          PRM_LIM_MAX:  nxt_s.lim_max  = param_wr.data;
          PRM_LIM_MIN:  nxt_s.lim_min  = param_wr.data;
          PRM_OUT_FN:   nxt_s.out_fn   = cve_out_fn_t'(param_wr.data[2:0]);
          PRM_AVG_MODE: nxt_s.avg_mode = cve_avg_mode_t'(param_wr.data[1:0]);
          PRM_ACT_MAX:  nxt_s.act_max  = cve_action_t'(param_wr.data[1:0]);
          PRM_ACT_MIN:  nxt_s.act_min  = cve_action_t'(param_wr.data[1:0]);
          PRM_SMOOTH: begin
            // a new count restarts the window so no stale entries leak in
            nxt_s.smooth_cnt = (param_wr.data[6:0] > `CVE_SMOOTH_MAX) ? `CVE_SMOOTH_MAX : param_wr.data[6:0];
            nxt_s.sum  = 23'sh000000;
            nxt_s.fill = 7'h00;
            nxt_s.idx  = 7'h00;
          end
          default: ;
        endcase
      end
    end
    // global hysteresis, clamped to its range
    if (hyst_we) begin
      nxt_s.hyst = (hyst_val > `CVE_HYST_MAX) ? `CVE_HYST_MAX : hyst_val;
    end
    if (sys_rst) begin
      nxt_s = '0;
      nxt_s.desig   = {20{`CVE_CH_BLANK}};
      nxt_s.hyst    = `CVE_HYST_RST;
      nxt_s.lim_max = `CVE_LIM_MAX_RST;
      nxt_s.lim_min = `CVE_LIM_MIN_RST;
    end
  end

  // state register
  always_ff @(posedge core_clk) begin
    s_ff <= nxt_s;
  end

  // designation view, marker forced into the last position
  for (genvar i = 0; i < 20; i++) begin : g_desig
    assign desig_out[i] = (lin_active && 5'(i) == len - 5'h01) ? `CVE_CH_MARK
                        : (5'(i) < len) ? s_ff.desig[i] : `CVE_CH_BLANK;
  end

  // prefix decode from the first two characters
  assign cj_ext_ref  = s_ff.desig[0] == `CVE_CH_STAR && s_ff.desig[1] == `CVE_CH_J;
  assign cj_internal = s_ff.desig[0] == `CVE_CH_HASH && s_ff.desig[1] == `CVE_CH_J && is_thermo;
  assign temp_ref    = s_ff.desig[0] == `CVE_CH_STAR && s_ff.desig[1] == `CVE_CH_T;
  assign press_ref   = s_ff.desig[0] == `CVE_CH_STAR && s_ff.desig[1] == `CVE_CH_P;
  assign std_cond    = s_ff.desig[0] == `CVE_CH_HASH && s_ff.desig[1] == `CVE_CH_N;

  // outputs
  assign desig_rej     = s_ff.desig_rej;
  assign param_done    = s_ff.wr_done;
  assign param_refused = s_ff.wr_refused;
  assign confirm_req   = s_ff.confirm_req;
  assign smooth_val    = s_ff.last;
  assign max_val       = s_ff.max;
  assign max_ts        = s_ff.max_ts;
  assign min_val       = s_ff.min;
  assign min_ts        = s_ff.min_ts;
  assign avg_val       = s_ff.avg_val;
  assign avg_n         = s_ff.avg_n;
  assign out_val       = s_ff.out_val;
  assign out_vld       = s_ff.out_vld;
  assign tc_tenths     = s_ff.tc;
  assign alarm_max     = s_ff.al_max;
  assign alarm_min     = s_ff.al_min;
  assign alarm_brk     = s_ff.al_brk;
  assign alarm_led     = s_ff.al_max | s_ff.al_min | s_ff.al_brk;
  assign beeper        = s_ff.al_max | s_ff.al_min | s_ff.al_brk;
  assign relay_max     = s_ff.al_max;
  assign relay_min     = s_ff.al_min;
  assign start_req     = s_ff.start_p;
  assign stop_req      = s_ff.stop_p;

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  lock_refuse_a: assert property (param_we && locked && !param_wr.confirm |=> param_refused && !param_done)
    else $error("locked write was not refused");
  confirm_write_a: assert property (param_we && locked && param_wr.confirm |=> param_done && !param_refused)
    else $error("confirmed write was not taken");
  hyst_range_a: assert property (s_ff.hyst <= `CVE_HYST_MAX)
    else $error("hysteresis out of range");
  alarm_set_a: assert property (smp_valid && cur > s_ff.lim_max |=> alarm_max && alarm_led && relay_max)
    else $error("overshoot did not raise alarm");
  alarm_hold_a: assert property (alarm_max && smp_valid && !param_we && 17'(cur) > rel_max |=> alarm_max)
    else $error("alarm released inside hysteresis band");
  max_track_a: assert property (smp_valid && !clr_mx && s_ff.mx_ok && cur > s_ff.max
                                |=> max_val == $past(cur) && max_ts == $past(now_ts))
    else $error("maximum not tracked");
  desig_reject_a: assert property (desig_we && desig_chr == `CVE_CH_SEMI ##1 !desig_we
                                   |-> desig_rej ##1 !desig_rej)
    else $error("bad designation character accepted");
  cyc_clear_a: assert property (cyc_clr && !smp_valid |=> avg_n == 16'h0000 && max_val == $past(s_ff.last))
    else $error("cycle start did not clear");
  start_act_a: assert property (s_ff.act_max == ACT_START && !s_ff.al_max && nxt_s.al_max |=> start_req)
    else $error("limit did not start measuring");

  alarm_seen_c:   cover property (alarm_max ##[1:50] !alarm_max);
  confirm_seen_c: cover property (param_refused ##[1:20] param_done);
  smooth_full_c:  cover property (sm_on && full && smp_valid);
endmodule

// [verif/cve_front_model.sv]
// front-end model: delivers conversion results to the evaluator
`timescale 1ns/1ps
module cve_front_model
  import cve_pkg::*;
(
  // clock
  input  wire logic   core_clk,
  // sample stream
  output cve_sample_t smp,
  output logic        smp_valid
);
  initial begin
    smp_valid = 1'b0;
    smp       = '0;
  end
  // one-cycle strobe; value is scrambled after so stale data is never trusted
  task automatic send(input logic signed [15:0] v, input logic b);
    @(negedge core_clk);
    smp_valid = 1'b1;
    smp       = '{val: v, over: 1'b0, under: 1'b0, brk: b, manual: 1'b0};
    @(negedge core_clk);
    smp_valid = 1'b0;
    smp.val   = ~v;
  endtask
endmodule

// [verif/cve_evaluator_test.sv]
// self-checking bench for the channel value evaluator
`timescale 1ns/1ps
module cve_evaluator_test;
  import cve_pkg::*;
  logic core_clk = 1'b0, sys_rst = 1'b1, smp_valid;
  cve_sample_t smp;
  cve_param_wr_t param_wr = '0;
  logic signed [15:0] ch0_val = '0, smooth_val, max_val, min_val, out_val, avg_val;
  logic [31:0] now_ts = '0, max_ts, min_ts;
  logic [15:0] tc_tenths, avg_n;
  logic [19:0][7:0] desig_out;
  logic [7:0] conv_rate_hz = 8'h0a, desig_chr = '0;
  logic [6:0] hyst_val = '0;
  logic [4:0] desig_idx = '0;
  logic [2:0] lock_level = '0;
  logic meas_running = 0, cycle_start = 0, auto_clr_start = 0, is_thermo = 0, is_extended = 0, is_legacy = 0;
  logic lin_active = 0, clr_max = 0, clr_min = 0, clr_all = 0, clr_avg = 0, desig_we = 0, param_we = 0, hyst_we = 0;
  logic desig_rej, std_cond, param_done, param_refused, confirm_req, alarm_max, alarm_min, alarm_brk;
  logic alarm_led, beeper, relay_max, relay_min, stop_req, start_req, out_vld, cj_ext_ref, cj_internal;
  logic temp_ref, press_ref;
  int err_total = 0, checks_done = 0;

  cve_front_model cve_front_model_i (.core_clk(core_clk), .smp(smp), .smp_valid(smp_valid));
  cve_evaluator cve_evaluator_i (.core_clk(core_clk), .sys_rst(sys_rst), .smp_valid(smp_valid), .smp(smp),
    .ch0_val(ch0_val), .now_ts(now_ts), .meas_running(meas_running), .cycle_start(cycle_start),
    .auto_clr_start(auto_clr_start), .is_thermo(is_thermo), .is_extended(is_extended), .is_legacy(is_legacy),
    .lin_active(lin_active), .conv_rate_hz(conv_rate_hz), .clr_max(clr_max), .clr_min(clr_min), .clr_all(clr_all),
    .clr_avg(clr_avg), .desig_we(desig_we), .desig_idx(desig_idx), .desig_chr(desig_chr), .desig_rej(desig_rej),
    .desig_out(desig_out), .cj_ext_ref(cj_ext_ref), .cj_internal(cj_internal), .temp_ref(temp_ref),
    .press_ref(press_ref), .std_cond(std_cond),
    .param_we(param_we), .param_wr(param_wr), .lock_level(lock_level), .hyst_we(hyst_we), .hyst_val(hyst_val),
    .param_done(param_done), .param_refused(param_refused), .confirm_req(confirm_req), .smooth_val(smooth_val),
    .max_val(max_val), .max_ts(max_ts), .min_val(min_val), .min_ts(min_ts), .avg_val(avg_val), .avg_n(avg_n),
    .out_val(out_val), .out_vld(out_vld), .tc_tenths(tc_tenths), .alarm_max(alarm_max), .alarm_min(alarm_min),
    .alarm_brk(alarm_brk), .alarm_led(alarm_led), .beeper(beeper), .relay_max(relay_max), .relay_min(relay_min),
    .start_req(start_req), .stop_req(stop_req));

  // 40 MHz clock; timestamp advances off the sampling edge
  always #12.5 core_clk = ~core_clk;
  always @(negedge core_clk) now_ts <= now_ts + 32'h1;

  task automatic cmp(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("Error at %0t: %s", $time, msg);
    end
  endtask
  task automatic end_of_test;
    if (err_total == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // one parameter write; verdict pulses stand for the cycle after the take
  task automatic param(input cve_param_t c, input logic [15:0] d, input logic cf, input logic ok);
    @(negedge core_clk);
    param_we = 1'b1;
    param_wr = '{cls: c, data: d, confirm: cf};
    @(negedge core_clk);
    param_we = 1'b0;
    cmp(param_done === ok && param_refused === !ok && confirm_req === !ok, "param write verdict");
  endtask
  task automatic desig(input logic [4:0] i, input logic [7:0] ch, input logic rej);
    @(negedge core_clk);
    {desig_we, desig_idx, desig_chr} = {1'b1, i, ch};
    @(negedge core_clk);
    desig_we = 1'b0;
    cmp(desig_rej === rej, "designation char verdict");
  endtask
  task automatic s_lock;
    lock_level = 3'h7;
    param(PRM_LIM_MAX, 16'h0064, 1'b0, 1'b0);
    param(PRM_LIM_MAX, 16'h0064, 1'b1, 1'b1);
    lock_level = 3'h3;
    param(PRM_UNITS, 16'h0001, 1'b0, 1'b0);
    param(PRM_SCALE, 16'h0001, 1'b0, 1'b1);
    lock_level = 3'h0;
    param(PRM_LIM_MIN, 16'hff9c, 1'b0, 1'b1);
  endtask
  // limits 100 / -100, default hysteresis 10 digits
  task automatic s_alarm;
    cve_front_model_i.send(16'sd101, 1'b0);
    cmp(alarm_max && relay_max && alarm_led && beeper && !alarm_min, "max alarm set");
    cve_front_model_i.send(16'sd91, 1'b0);
    cmp(alarm_max === 1'b1, "max alarm held in band");
    cve_front_model_i.send(16'sd90, 1'b0);
    cmp(alarm_max === 1'b0, "max alarm release");
    cve_front_model_i.send(-16'sd101, 1'b0);
    cmp(alarm_min && relay_min && !relay_max, "min alarm set");
    @(negedge core_clk);
    {hyst_we, hyst_val} = {1'b1, 7'h00};
    @(negedge core_clk);
    hyst_we = 1'b0;
    cve_front_model_i.send(-16'sd100, 1'b0);
    cmp(alarm_min === 1'b0, "min release at zero hysteresis");
    cve_front_model_i.send(16'sd0, 1'b1);
    cmp(alarm_brk && alarm_led && beeper, "sensor break alarm");
    param(PRM_ACT_MAX, 16'h0002, 1'b0, 1'b1);
    cve_front_model_i.send(16'sd200, 1'b0);
    cmp(stop_req === 1'b1, "stop on max violation");
  endtask
  task automatic s_values;
    param(PRM_SMOOTH, 16'h0002, 1'b0, 1'b1);
    // time constant follows the stored count one edge later
    @(negedge core_clk);
    cmp(tc_tenths === 16'h0002, "time constant");
    cve_front_model_i.send(16'sd10, 1'b0);
    cve_front_model_i.send(16'sd20, 1'b0);
    cve_front_model_i.send(16'sd40, 1'b0);
    cmp(smooth_val === 16'sd30, "sliding average");
    @(negedge core_clk);
    clr_all = 1'b1;
    @(negedge core_clk);
    clr_all = 1'b0;
    @(negedge core_clk);
    cmp(max_val === 16'sd30 && min_val === 16'sd30, "clear reloads smoothed value");
    param(PRM_SMOOTH, 16'h0000, 1'b0, 1'b1);
    cve_front_model_i.send(16'sd50, 1'b0);
    cve_front_model_i.send(-16'sd7, 1'b0);
    cmp(max_val === 16'sd50 && min_val === -16'sd7, "max and min tracking");
    ch0_val = 16'sd2;
    param(PRM_OUT_FN, 16'h0001, 1'b0, 1'b1);
    cve_front_model_i.send(16'sd10, 1'b0);
    cmp(out_val === 16'sd8 && out_vld === 1'b1, "difference output");
  endtask
  // per-cycle averaging, cyclic clear, start action, clear on measuring start
  task automatic s_avg;
    param(PRM_AVG_MODE, 16'h0002, 1'b0, 1'b1);
    cve_front_model_i.send(16'sd10, 1'b0);
    cve_front_model_i.send(16'sd20, 1'b0);
    cmp(avg_n === 16'h0002, "average count");
    @(negedge core_clk);
    cmp(avg_val === 16'sd15, "per-cycle average");
    cycle_start = 1'b1;
    @(negedge core_clk);
    cycle_start = 1'b0;
    cmp(avg_n === 16'h0000 && max_val === 16'sd20 && min_val === 16'sd20, "cyclic clear");
    cmp(max_ts === now_ts, "maximum timestamp");
    param(PRM_ACT_MAX, 16'h0001, 1'b0, 1'b1);
    cve_front_model_i.send(16'sd150, 1'b0);
    cmp(start_req === 1'b1, "start on max violation");
    {auto_clr_start, meas_running} = 2'b11;
    @(negedge core_clk);
    cmp(min_val === 16'sd150 && min_ts === now_ts && avg_n === 16'h0000, "clear on start");
  endtask
  task automatic s_desig;
    desig(5'd0, 8'h23, 1'b0);
    desig(5'd1, 8'h4e, 1'b0);
    @(negedge core_clk);
    cmp(std_cond === 1'b1, "standard conditions prefix");
    desig(5'd2, 8'h3b, 1'b1);
    desig(5'd10, 8'h41, 1'b1);
    desig(5'd0, 8'h2a, 1'b0);
    desig(5'd1, 8'h54, 1'b0);
    @(negedge core_clk);
    cmp(temp_ref === 1'b1 && press_ref === 1'b0 && std_cond === 1'b0, "temperature prefix");
    is_thermo = 1'b1;
    desig(5'd0, 8'h23, 1'b0);
    desig(5'd1, 8'h4a, 1'b0);
    @(negedge core_clk);
    cmp(cj_internal === 1'b1 && cj_ext_ref === 1'b0, "connector cold junction prefix");
    lin_active = 1'b1;
    desig(5'd9, 8'h41, 1'b1);
    cmp(desig_out[9] === 8'h7e, "linearization marker");
  endtask

  initial begin
    repeat (10) @(posedge core_clk);
    @(negedge core_clk);
    sys_rst = 1'b0;
    s_lock();
    s_alarm();
    s_values();
    s_avg();
    s_desig();
    end_of_test();
  end
endmodule
